// ===== design/hspc_pkg.sv
// Package for the halt and standby power controller.
// Assumes a single 10 MHz reference clock and synchronous active-low reset.
`default_nettype none
package hspc_pkg;
  // ----------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------
  localparam int unsigned HSPC_ADDR_W = 12;
  localparam int unsigned HSPC_DATA_W = 8;
  localparam logic [11:0] HSPC_RESET_VECTOR = 12'h000;
  localparam logic [11:0] HSPC_ADDR_STEP = 12'h001;
  localparam logic [1:0] HSPC_INT_SKIP = 2'h2;
  localparam logic [1:0] HSPC_SKIP_DONE = 2'h0;
  localparam logic [7:0] HSPC_EVT_RESET = 8'h00;
  localparam logic [7:0] HSPC_EVT_STEP = 8'h01;
  localparam logic [7:0] HSPC_BUS_RESET = 8'h00;
  localparam logic [7:0] HSPC_PORT_RESET = 8'hff;

  // Power states, one-hot
  typedef enum logic [3:0] {
    HSPC_RUN = 4'h1,
    HSPC_HALT = 4'h2,
    HSPC_INTWAIT = 4'h4,
    HSPC_STANDBY_REQUEST_N = 4'h8
  } hspc_state_t;

  // Pin snapshot held across halt
  typedef struct packed {
    logic [7:0] bus_out;
    logic bus_drive;
    logic [7:0] port1;
    logic [7:0] port2;
    logic clk_out_en;
  } hspc_pins_t;

  // Requests from the processor core
  typedef struct packed {
    logic halt_exec;
    logic instr_done;
    logic int_enabled;
    logic [11:0] halt_addr;
  } hspc_core_t;
endpackage
`default_nettype wire

// ===== design/hspc_sync.sv
// Two-flop synchroniser for pins entering the reference clock domain.
// Assumes rstn is synchronous to ref_clk; resets to the given level.
`default_nettype none
module hspc_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic meta;
  // First flop feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== design/hspc_top.sv
// Halt and standby power control for an 8-bit microcomputer core.
// Assumes core signals share ref_clk; pins pass a two-flop synchroniser.
//
// Overview of operation
// - Halt instruction stops execution until release
// - Halted: basic clock keeps running
// - Halted: processor registers keep their values
// - Halted: data bus keeps drive or float
// - Halted: test0 clock output keeps running
// - Halted: every event pulse is still counted
// - Event count continues after halt, uncleared
// - Reset during halt restarts at address 0
// - Interrupt enabled: two instructions, then interrupt
// - Interrupt disabled: resume after halt instruction
// - Standby stops all but internal RAM
// - Reset release after standby restarts at 0
`default_nettype none
module hspc_top
  import hspc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  input wire logic standby_request_n,
  input wire logic int_n,
  input wire logic event_count_input,
  input wire logic clk_div_tick,
  input wire hspc_pkg::hspc_core_t core,
  input wire hspc_pkg::hspc_pins_t pins,
  output logic core_run,
  output logic core_reset,
  output logic osc_enable,
  output logic ram_retain,
  output logic int_start,
  output logic [11:0] resume_addr,
  output logic resume_load,
  output logic [7:0] bus_out,
  output logic bus_oe_n,
  output logic [7:0] port1_out,
  output logic [7:0] port2_out,
  output logic addr_strobe,
  output logic test0_clock_out,
  output logic timer_run,
  output logic [7:0] event_count
);
  import hspc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic reset_s_n;
  logic standby_request_n_s_n;
  logic int_s_n;
  logic evt_s;
  hspc_sync #(.INIT(1'b0)) u_rst (.ref_clk(ref_clk), .rstn(rstn), .din(reset_pin_n),
    .dout(reset_s_n));
  hspc_sync #(.INIT(1'b1)) u_standby_request_n (.ref_clk(ref_clk), .rstn(rstn), .din(standby_request_n),
    .dout(standby_request_n_s_n));
  hspc_sync #(.INIT(1'b1)) u_int (.ref_clk(ref_clk), .rstn(rstn), .din(int_n),
    .dout(int_s_n));
  hspc_sync #(.INIT(1'b0)) u_evt (.ref_clk(ref_clk), .rstn(rstn), .din(event_count_input),
    .dout(evt_s));

  // ----------------------------------------------------------------
  // State and held values
  // ----------------------------------------------------------------
  hspc_state_t state;
  hspc_state_t next_state;
  hspc_pins_t held;
  logic [1:0] skip_cnt;
  logic evt_prev;
  logic int_pending;

  // Decoding of conditions
  wire in_run = (state == HSPC_RUN);
  wire in_halt = (state == HSPC_HALT);
  wire in_wait = (state == HSPC_INTWAIT);
  wire in_standby_request_n = (state == HSPC_STANDBY_REQUEST_N);
  wire reset_low = !reset_s_n;
  wire enter_standby_request_n = reset_low && !standby_request_n_s_n;
  wire halt_go = in_run && core.halt_exec;
  wire int_wake = in_halt && !int_s_n;
  wire evt_rise = evt_s && !evt_prev;
  wire skip_last = in_wait && core.instr_done && (skip_cnt == HSPC_INT_SKIP - HSPC_ADDR_STEP[1:0]);
  wire [11:0] next_addr = core.halt_addr + HSPC_ADDR_STEP;

  // Next state selection
  always_comb begin
    next_state = state;
    case (state)
      HSPC_RUN: begin
        if (halt_go) begin
          next_state = HSPC_HALT;
        end
      end
      HSPC_HALT: begin
        if (int_wake && core.int_enabled) begin
          next_state = HSPC_INTWAIT;
        end else if (int_wake) begin
          next_state = HSPC_RUN;
        end
      end
      HSPC_INTWAIT: begin
        if (skip_last) begin
          next_state = HSPC_RUN;
        end
      end
      HSPC_STANDBY_REQUEST_N: begin
        next_state = HSPC_STANDBY_REQUEST_N;
      end
      default: begin
        next_state = HSPC_RUN;
      end
    endcase
    if (enter_standby_request_n) begin
      next_state = HSPC_STANDBY_REQUEST_N;
    end else if (reset_low) begin
      next_state = HSPC_RUN;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= HSPC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Two-instruction count after an enabled wake-up
  always_ff @(posedge ref_clk) begin
    if (!rstn || !in_wait) begin
      skip_cnt <= HSPC_SKIP_DONE;
    end else if (core.instr_done) begin
      skip_cnt <= skip_cnt + HSPC_ADDR_STEP[1:0];
    end
  end

  // Snapshot of pin state taken as halt begins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      held <= '0;
    end else if (halt_go) begin
      held <= pins;
    end
  end

  // Core control; core registers freeze while core_run is low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      core_run <= 1'b0;
      core_reset <= 1'b1;
      osc_enable <= 1'b1;
      ram_retain <= 1'b0;
      resume_load <= 1'b0;
      resume_addr <= HSPC_RESET_VECTOR;
      int_pending <= 1'b0;
      int_start <= 1'b0;
    end else begin
      // A core held in reset stays stopped until the pin is released
      core_run <= ((next_state == HSPC_RUN) || (next_state == HSPC_INTWAIT))
        && !reset_low;
      core_reset <= reset_low;
      osc_enable <= (next_state != HSPC_STANDBY_REQUEST_N);
      ram_retain <= (next_state == HSPC_STANDBY_REQUEST_N);
      resume_load <= reset_low || (int_wake && !core.int_enabled);
      if (reset_low) begin
        resume_addr <= HSPC_RESET_VECTOR;
      end else if (int_wake && !core.int_enabled) begin
        resume_addr <= next_addr;
      end
      int_pending <= (int_pending || (int_wake && core.int_enabled)) && !reset_low
        && !skip_last;
      int_start <= int_pending && skip_last;
    end
  end

  // Pin drive: live when running, held during halt, quiet in standby
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bus_out <= HSPC_BUS_RESET;
      bus_oe_n <= 1'b1;
      port1_out <= HSPC_PORT_RESET;
      port2_out <= HSPC_PORT_RESET;
      addr_strobe <= 1'b0;
      test0_clock_out <= 1'b0;
      timer_run <= 1'b0;
    end else if (in_halt) begin
      bus_out <= held.bus_out;
      bus_oe_n <= !held.bus_drive;
      port1_out <= held.port1;
      port2_out <= held.port2;
      addr_strobe <= 1'b0;
      test0_clock_out <= held.clk_out_en && clk_div_tick;
      timer_run <= 1'b0;
    end else if (in_standby_request_n) begin
      bus_oe_n <= 1'b1;
      addr_strobe <= 1'b0;
      test0_clock_out <= 1'b0;
      timer_run <= 1'b0;
    end else begin
      bus_out <= pins.bus_out;
      bus_oe_n <= !pins.bus_drive;
      port1_out <= pins.port1;
      port2_out <= pins.port2;
      addr_strobe <= clk_div_tick && !reset_low;
      test0_clock_out <= pins.clk_out_en && clk_div_tick;
      timer_run <= !reset_low;
    end
  end

  // Event counter keeps counting through and after halt
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      evt_prev <= 1'b0;
      event_count <= HSPC_EVT_RESET;
    end else begin
      evt_prev <= evt_s;
      if (reset_low) begin
        event_count <= HSPC_EVT_RESET;
      end else if (evt_rise && !in_standby_request_n) begin
        event_count <= event_count + HSPC_EVT_STEP;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/hspc_partner.sv
// Model of the outside reset, standby and interrupt circuitry.
// Assumes the caller steps it from ref_clk; pins change at rising edges.
`default_nettype none
module hspc_partner (
  input wire logic ref_clk,
  output logic reset_pin_n,
  output logic standby_request_n,
  output logic int_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // Pin sequencing
  // -------------------------------------------------------------
  // Reset held at power-up, standby kept high in normal use
  initial begin
    reset_pin_n = 1'b0;
    standby_request_n = 1'b1;
    int_n = 1'b1;
  end
  // Moves all three pins together at one edge
  task automatic step(input logic r, input logic s, input logic i);
    @(posedge ref_clk);
    reset_pin_n <= r;
    standby_request_n <= s;
    int_n <= i;
  endtask
  // Reset goes low first, then standby
  task automatic enter_standby;
    step(1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge ref_clk);
    step(1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge ref_clk);
  endtask
  // Standby rises while reset still low, reset released last
  task automatic leave_standby;
    step(1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge ref_clk);
    step(1'b1, 1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== tb/hspc_top_sva.sv
// Concurrent checks on the power controller ports.
// Assumes it is bound to hspc_top and sees only its ports.
`default_nettype none
module hspc_sva
  import hspc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic int_n,
  input wire hspc_pkg::hspc_core_t core,
  input wire logic core_run,
  input wire logic core_reset,
  input wire logic osc_enable,
  input wire logic ram_retain,
  input wire logic [11:0] resume_addr,
  input wire logic resume_load,
  input wire logic bus_oe_n,
  input wire logic [7:0] port1_out,
  input wire logic addr_strobe,
  input wire logic timer_run,
  input wire logic [7:0] event_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_halt_stops_run: assert property (core_run && core.halt_exec |=> !core_run)
    else $error("core kept running after halt");
  a_halt_holds_pins: assert property (!core_run && !$past(core_run) && !core_reset
    && !$past(core_reset) && osc_enable |-> $stable(port1_out) && $stable(bus_oe_n))
    else $error("pin outputs moved in halt");
  a_halt_quiet_out: assert property (!core_run && !$past(core_run) && !core_reset
    && osc_enable |-> !addr_strobe && !timer_run)
    else $error("strobe or timer active in halt");
  a_event_no_clear: assert property (!core_reset && !$past(core_reset)
    |-> 8'(event_count - $past(event_count)) <= 8'h01)
    else $error("event count jumped or cleared");
  a_int_wakes_core: assert property ($fell(int_n) && !core_run && !core_reset
    && osc_enable |-> ##[1:4] core_run)
    else $error("interrupt did not wake core");
  a_resume_next_addr: assert property ($rose(core_run) && resume_load
    && !$past(core_reset) |-> resume_addr == core.halt_addr + HSPC_ADDR_STEP)
    else $error("wrong resume address");
  a_standby_osc_off: assert property (!osc_enable |-> ram_retain && !core_run)
    else $error("standby not fully stopped");
  a_reset_stops_core: assert property (core_reset |-> !core_run)
    else $error("core runs under reset");
endmodule
bind hspc_top hspc_sva hspc_sva_inst (.ref_clk, .rstn, .int_n, .core, .core_run,
  .core_reset, .osc_enable, .ram_retain, .resume_addr, .resume_load, .bus_oe_n,
  .port1_out, .addr_strobe, .timer_run, .event_count);
`default_nettype wire

// ===== tb/tb_halt_standby_power_control.sv
// Self-checking bench for the halt and standby power controller.
// Assumes the partner model owns the reset, standby and interrupt pins.
`default_nettype none
module tb_halt_standby_power_control
  import hspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rstn = 1'b0, ev = 1'b0, tick = 1'b0;
  logic rpin, spin, ipin, run, crst, osc, ret, istart, rload, oe_n, strobe, t0, trun;
  logic [11:0] raddr;
  logic [7:0] bout, p1, p2, evc;
  hspc_core_t core = '0;
  hspc_pins_t pins = '0, held;
  int n_fail = 0, checks = 0, exp_ev = 0, n_int = 0;
  // -------------------------------------------------------------
  // Clock, instances and monitors
  // -------------------------------------------------------------
  initial forever #50 ref_clk = ~ref_clk;
  hspc_partner hspc_partner_inst (.ref_clk, .reset_pin_n(rpin), .standby_request_n(spin),
    .int_n(ipin));
  hspc_top hspc_top_inst (.ref_clk, .rstn, .reset_pin_n(rpin), .standby_request_n(spin),
    .int_n(ipin), .event_count_input(ev), .clk_div_tick(tick), .core, .pins,
    .core_run(run), .core_reset(crst), .osc_enable(osc), .ram_retain(ret),
    .int_start(istart), .resume_addr(raddr), .resume_load(rload), .bus_out(bout),
    .bus_oe_n(oe_n), .port1_out(p1), .port2_out(p2), .addr_strobe(strobe),
    .test0_clock_out(t0), .timer_run(trun), .event_count(evc));
  // Internal clock phase and interrupt start counter
  always @(posedge ref_clk) begin
    tick <= ~tick;
    if (istart === 1'b1) n_int <= n_int + 1;
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_run;
    for (int i = 0; i < 20 && run !== 1'b1; i++) @(negedge ref_clk);
    chk("core_run", 12'h001, {11'h0, run});
  endtask
  task automatic pulse(input int sel);
    @(posedge ref_clk);
    if (sel == 0) ev <= 1'b1;
    else core.instr_done <= 1'b1;
    @(posedge ref_clk);
    ev <= 1'b0;
    core.instr_done <= 1'b0;
    if (sel == 0) exp_ev++;
    cyc(3);
  endtask
  // Enters halt, changes live pins and checks the held ones
  task automatic halt(input logic ie);
    @(posedge ref_clk);
    core.int_enabled <= ie;
    pins <= 26'($urandom);
    cyc(4);
    @(posedge ref_clk) core.halt_exec <= 1'b1;
    @(posedge ref_clk) core.halt_exec <= 1'b0;
    cyc(4);
    held = pins;
    @(posedge ref_clk) pins <= 26'($urandom);
    pulse(0);
    chk("core_run", 12'h000, {11'h0, run});
    chk("osc_enable", 12'h001, {11'h0, osc});
    chk("port1_out", {4'h0, held.port1}, {4'h0, p1});
    chk("port2_out", {4'h0, held.port2}, {4'h0, p2});
    chk("bus_oe_n", {11'h0, !held.bus_drive}, {11'h0, oe_n});
    chk("bus_out", {4'h0, held.bus_out}, {4'h0, bout});
    chk("test0_clock_out", {11'h0, held.clk_out_en & ~tick}, {11'h0, t0});
    chk("strobe_timer", 12'h000, {10'h0, strobe, trun});
    chk("event_count", 12'(exp_ev), {4'h0, evc});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // -------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------
  initial begin
    void'($urandom(36));
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    core.halt_addr <= 12'($urandom);
    hspc_partner_inst.step(1'b1, 1'b1, 1'b1);
    wait_run();
    halt(1'b0);
    hspc_partner_inst.step(1'b1, 1'b1, 1'b0);
    wait_run();
    chk("resume_load", 12'h001, {11'h0, rload});
    chk("resume_addr", core.halt_addr + HSPC_ADDR_STEP, raddr);
    hspc_partner_inst.step(1'b1, 1'b1, 1'b1);
    $display("test halt_int_disabled done");
    halt(1'b1);
    hspc_partner_inst.step(1'b1, 1'b1, 1'b0);
    wait_run();
    hspc_partner_inst.step(1'b1, 1'b1, 1'b1);
    pulse(1);
    chk("int_start_early", 12'h000, 12'(n_int));
    pulse(1);
    chk("int_start", 12'h001, 12'(n_int));
    $display("test halt_int_enabled done");
    halt(1'b0);
    hspc_partner_inst.step(1'b0, 1'b1, 1'b1);
    cyc(4);
    exp_ev = 0;
    chk("reset_in_halt", {2'h0, 2'h2, 8'(exp_ev)}, {2'h0, crst, run, evc});
    hspc_partner_inst.step(1'b1, 1'b1, 1'b1);
    wait_run();
    $display("test halt_reset done");
    hspc_partner_inst.enter_standby();
    cyc(1);
    chk("standby", 12'h001, {10'h0, osc, ret});
    chk("standby_run", 12'h000, {11'h0, run});
    hspc_partner_inst.leave_standby();
    wait_run();
    chk("standby_exit", 12'h200, {3'h0, osc, ret, evc});
    $display("test standby done");
    end_sim();
  end
endmodule
`default_nettype wire
